//--- core/ewsc_defines.svh
// Constants for the memory word check and correct block
`ifndef EWSC_DEFINES_SVH
`define EWSC_DEFINES_SVH
`define EWSC_WORD_W        16
`define EWSC_DATA_W        11
`define EWSC_ADDR_W        7
`define EWSC_DATA_LSB      5
`define EWSC_PAR_POS       4
`define EWSC_WORDS         8'h80
`define EWSC_LAST_ADDR     7'h7F
`define EWSC_CFG_WORDS     8
`define EWSC_CFG_LAST      7'h07
`define EWSC_FATAL_BIT     1
`define EWSC_ADDR_IR_GAIN_A 7'h00
`define EWSC_ADDR_IR_GAIN_B 7'h01
`define EWSC_ADDR_TEMP_GAIN 7'h02
`define EWSC_ADDR_CMP_SUP   7'h03
`define EWSC_ADDR_OUT_SENS  7'h04
`define EWSC_ADDR_OSC_CTRL  7'h05
`define EWSC_ADDR_REF_CTRL  7'h06
`define EWSC_ADDR_AVG_FILT  7'h07
`define EWSC_ADDR_CMP1_TH   7'h73
`define EWSC_ADDR_CMP1_HS   7'h74
`define EWSC_ADDR_REL_TH    7'h75
`define EWSC_ADDR_REL_HS    7'h76
`define EWSC_ADDR_USER      7'h78
`endif

//--- core/ewsc_pkg.sv
// Types for the memory word check and correct block
package ewsc_pkg;
    typedef enum logic [6:0] {
        EWSC_IDLE   = 7'b000_0001,
        EWSC_READ   = 7'b000_0010,
        EWSC_WAIT   = 7'b000_0100,
        EWSC_CHECK  = 7'b000_1000,
        EWSC_FIX    = 7'b001_0000,
        EWSC_LOAD   = 7'b010_0000,
        EWSC_RUN    = 7'b100_0000
    } ewsc_state_type;
endpackage

//--- core/ewsc_codec.sv
// Power-on check, correct and load of protected configuration memory words
`timescale 1ns/100ps
`include "ewsc_defines.svh"

module ewsc_codec (
    input  wire logic                         core_clk_i,
    input  wire logic                         sys_rst_i,
    output logic [6:0]                        mem_addr_o,
    output logic                              mem_rd_o,
    input  wire logic                         mem_rd_valid_i,
    input  wire logic [15:0]                  mem_rd_data_i,
    output logic                              mem_wr_o,
    output logic [15:0]                       mem_wr_data_o,
    input  wire logic                         mem_wr_done_i,
    output logic [15:0]                       cfg_word_o [0:7],
    output logic [3:0]                        status_o,
    output logic                              fatal_memory_error_flag_o,
    output logic                              check_done_o,
    output logic                              ready_o,
    output ewsc_pkg::ewsc_state_type          state_o,
    input  wire logic [6:0]                   rd_addr_i,
    output logic [10:0]                       rd_payload_o
);
    import ewsc_pkg::*;

    // ----------------------------------------
    // Parity and code functions
    // ----------------------------------------
    function automatic logic parity_of(input logic [15:0] v);
        parity_of = ^v;
    endfunction

    function automatic logic [3:0] check_bits(input logic [10:0] d);
        logic [3:0] h;
        h[0] = parity_of({9'h000, d[0], d[1], d[3], d[4], d[6], d[8], d[10]});
        h[1] = parity_of({9'h000, d[0], d[2], d[3], d[5], d[6], d[9], d[10]});
        h[2] = parity_of({9'h000, d[1], d[2], d[3], d[7], d[8], d[9], d[10]});
        h[3] = parity_of({9'h000, d[10:4]});
        check_bits = h;
    endfunction

    function automatic logic [15:0] encode(input logic [10:0] d);
        logic [3:0] h;
        h = check_bits(d);
        encode = {d, parity_of({1'b0, d, h}), h};
    endfunction

    // Maps a syndrome onto the data bit it names; 4'hF means none
    function automatic logic [3:0] syn_to_data(input logic [3:0] s);
        logic [3:0] r;
        r = 4'hF;
        for (int i = 0; i < 11; i++) begin
            if (check_bits(11'(1 << i)) == s) begin
                r = 4'(i);
            end
        end
        syn_to_data = r;
    endfunction

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    ewsc_state_type state_reg, state_next;
    logic [7:0]     addr_reg, addr_next;
    logic [15:0]    word_reg, word_next;
    logic           fatal_reg, fatal_next;
    logic [15:0]    cfg_reg [0:7];
    logic [15:0]    cfg_next [0:7];
    logic [10:0]    shadow_reg [0:127];
    logic           shadow_we;
    logic [10:0]    shadow_wd;
    logic [10:0]    pay_reg, pay_next;

    logic [3:0]     syndrome;
    logic           mismatch;
    logic [3:0]     dpos;
    logic [15:0]    fixed_word;

    always_comb begin
        syndrome   = check_bits(word_reg[15:5]) ^ word_reg[3:0];
        mismatch   = parity_of(word_reg);
        dpos       = syn_to_data(syndrome);
        fixed_word = word_reg;
        if (dpos != 4'hF) begin
            fixed_word[`EWSC_DATA_LSB + dpos] = ~word_reg[`EWSC_DATA_LSB + dpos];
        end
        fixed_word = encode(fixed_word[15:5]);
    end

    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        word_next  = word_reg;
        fatal_next = fatal_reg;
        shadow_we  = 1'b0;
        shadow_wd  = word_reg[15:5];
        for (int i = 0; i < `EWSC_CFG_WORDS; i++) begin
            cfg_next[i] = cfg_reg[i];
        end
        unique case (state_reg)
            EWSC_IDLE: begin
                addr_next  = 8'h00;
                state_next = EWSC_READ;
            end
            EWSC_READ: begin
                state_next = EWSC_WAIT;
            end
            EWSC_WAIT: begin
                if (mem_rd_valid_i) begin
                    word_next  = mem_rd_data_i;
                    state_next = EWSC_CHECK;
                end
            end
            EWSC_CHECK: begin
                shadow_we = 1'b1;
                if (syndrome != 4'h0 && !mismatch) begin
                    fatal_next = 1'b1;
                end else if (mismatch) begin
                    word_next  = fixed_word;
                    shadow_wd  = fixed_word[15:5];
                    state_next = EWSC_FIX;
                end
                if (!(mismatch) || (syndrome != 4'h0 && !mismatch)) begin
                    if (addr_reg[6:0] == `EWSC_LAST_ADDR) begin
                        addr_next  = 8'h00;
                        state_next = EWSC_LOAD;
                    end else begin
                        addr_next  = addr_reg + 8'h01;
                        state_next = EWSC_READ;
                    end
                end
            end
            EWSC_FIX: begin
                if (mem_wr_done_i) begin
                    if (addr_reg[6:0] == `EWSC_LAST_ADDR) begin
                        addr_next  = 8'h00;
                        state_next = EWSC_LOAD;
                    end else begin
                        addr_next  = addr_reg + 8'h01;
                        state_next = EWSC_READ;
                    end
                end
            end
            EWSC_LOAD: begin
                for (int i = 0; i < `EWSC_CFG_WORDS; i++) begin
                    cfg_next[i] = encode(shadow_reg[i]);
                end
                state_next = EWSC_RUN;
            end
            EWSC_RUN: begin
                state_next = EWSC_RUN;
            end
            default: begin
                state_next = EWSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            state_reg <= EWSC_IDLE;
            addr_reg  <= 8'h00;
            word_reg  <= 16'h0000;
            fatal_reg <= 1'b0;
            for (int i = 0; i < `EWSC_CFG_WORDS; i++) begin
                cfg_reg[i] <= 16'h0000;
            end
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            word_reg  <= word_next;
            fatal_reg <= fatal_next;
            for (int i = 0; i < `EWSC_CFG_WORDS; i++) begin
                cfg_reg[i] <= cfg_next[i];
            end
        end
    end

    // ----------------------------------------
    // Payload shadow and read extraction
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (shadow_we) begin
            shadow_reg[addr_reg[6:0]] <= shadow_wd;
        end
    end

    always_comb begin
        pay_next = shadow_reg[rd_addr_i];
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pay_reg <= 11'h000;
        end else begin
            pay_reg <= pay_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign mem_addr_o                = addr_reg[6:0];
    assign mem_rd_o                  = (state_reg == EWSC_READ);
    assign mem_wr_o                  = (state_reg == EWSC_FIX);
    assign mem_wr_data_o             = word_reg;
    assign cfg_word_o                = cfg_reg;
    assign status_o                  = {2'b00, fatal_reg, 1'b0};
    assign fatal_memory_error_flag_o = fatal_reg;
    assign check_done_o              = (state_reg == EWSC_LOAD) || (state_reg == EWSC_RUN);
    assign ready_o                   = (state_reg == EWSC_RUN);
    assign state_o                   = state_reg;
    assign rd_payload_o              = pay_reg;
endmodule

//--- tb/ewsc_codec_monitor.sv
// Assertion checker for the codec ports
`timescale 1ns/100ps
module ewsc_codec_monitor (
    input wire logic        core_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        mem_rd_o,
    input wire logic        mem_wr_o,
    input wire logic [15:0] mem_wr_data_o,
    input wire logic        mem_wr_done_i,
    input wire logic [3:0]  status_o,
    input wire logic        fatal_memory_error_flag_o,
    input wire logic        check_done_o,
    input wire logic        ready_o
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    function automatic logic [3:0] chk(input logic [10:0] d);
        return {^(d & 11'h7F0), ^(d & 11'h78E), ^(d & 11'h66D), ^(d & 11'h55B)};
    endfunction
    sequence s_rd;
        mem_rd_o ##1 !mem_rd_o && !mem_wr_o;
    endsequence
    sequence s_wr;
        mem_wr_o && !mem_wr_done_i;
    endsequence
    AST_RD_PULSE: assert property (mem_rd_o |-> s_rd) else $error("read strobe");
    AST_WR_HOLD: assert property (s_wr |=> mem_wr_o && $stable(mem_wr_data_o)) else $error("write hold");
    AST_WR_CHECK: assert property (mem_wr_o |-> mem_wr_data_o[3:0] == chk(mem_wr_data_o[15:5]))
        else $error("check bits");
    AST_WR_PARITY: assert property (mem_wr_o |-> !(^mem_wr_data_o)) else $error("parity bit");
    AST_STATUS: assert property (status_o == {2'b00, fatal_memory_error_flag_o, 1'b0})
        else $error("status");
    AST_FATAL_HOLD: assert property (fatal_memory_error_flag_o |=> fatal_memory_error_flag_o)
        else $error("fatal lost");
    AST_READY_HOLD: assert property (ready_o |=> ready_o && check_done_o) else $error("ready lost");
    AST_QUIET: assert property (check_done_o |-> !mem_rd_o && !mem_wr_o) else $error("access after check");
endmodule
bind ewsc_codec ewsc_codec_monitor u_mon (.core_clk_i, .sys_rst_i, .mem_rd_o, .mem_wr_o, .mem_wr_data_o,
    .mem_wr_done_i, .status_o, .fatal_memory_error_flag_o, .check_done_o, .ready_o);

//--- tb/ewsc_mem_model.sv
// Memory array model with programmable answer delay
`timescale 1ns/100ps
module ewsc_mem_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  lat_i,
    input  wire logic [6:0]  addr_i,
    input  wire logic        rd_i,
    output logic             rd_valid_o,
    output logic [15:0]      rd_data_o,
    input  wire logic        wr_i,
    input  wire logic [15:0] wr_data_i,
    output logic             wr_done_o
);
    logic [15:0] mem [0:127];
    logic [7:0]  rcnt = 8'h00;
    logic [7:0]  wcnt = 8'h00;
    logic        rpend = 1'b0;
    logic        wbusy = 1'b0;
    int          wr_cnt = 0;
    initial begin
        rd_valid_o = 1'b0;
        wr_done_o = 1'b0;
        rd_data_o = 16'h0000;
    end
    always @(posedge clk_i) begin
        rd_valid_o <= 1'b0;
        wr_done_o <= 1'b0;
        if (rd_i) begin
            rpend <= 1'b1;
            rcnt <= lat_i;
        end else if (rpend && rcnt != 8'h00) begin
            rcnt <= rcnt - 8'h01;
        end else if (rpend) begin
            rpend <= 1'b0;
            rd_valid_o <= 1'b1;
            rd_data_o <= mem[addr_i];
        end else if (rd_valid_o) begin
            rd_data_o <= ~rd_data_o;
        end
        if (wr_i && !wr_done_o && !wbusy) begin
            wbusy <= 1'b1;
            wcnt <= lat_i;
        end else if (wbusy && wcnt != 8'h00) begin
            wcnt <= wcnt - 8'h01;
        end else if (wbusy) begin
            wbusy <= 1'b0;
            wr_done_o <= 1'b1;
            mem[addr_i] <= wr_data_i;
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking testbench for the codec
`timescale 1ns/100ps
module tb_top;
    logic        core_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [6:0]  rd_addr_i = 7'h00;
    logic [7:0]  lat = 8'h00;
    logic [6:0]  mem_addr_o;
    logic        mem_rd_o, mem_rd_valid_i, mem_wr_o, mem_wr_done_i, fatal, check_done_o, ready_o;
    logic [15:0] mem_rd_data_i, mem_wr_data_o;
    logic [15:0] cfg_word_o [0:7];
    logic [3:0]  status_o;
    logic [10:0] rd_payload_o;
    int          bad_count = 0;
    int          n_tests = 0;
    ewsc_pkg::ewsc_state_type state_o;
    always #10 core_clk_i = ~core_clk_i;
    ewsc_codec uut (.core_clk_i, .sys_rst_i, .mem_addr_o, .mem_rd_o, .mem_rd_valid_i, .mem_rd_data_i, .mem_wr_o,
        .mem_wr_data_o, .mem_wr_done_i, .cfg_word_o, .status_o, .fatal_memory_error_flag_o(fatal), .check_done_o,
        .ready_o, .state_o, .rd_addr_i, .rd_payload_o);
    ewsc_mem_model mdl (.clk_i(core_clk_i), .lat_i(lat), .addr_i(mem_addr_o), .rd_i(mem_rd_o),
        .rd_valid_o(mem_rd_valid_i), .rd_data_o(mem_rd_data_i), .wr_i(mem_wr_o), .wr_data_i(mem_wr_data_o),
        .wr_done_o(mem_wr_done_i));
    function automatic logic [15:0] enc(input logic [10:0] d);
        logic [3:0] h;
        h = {^(d & 11'h7F0), ^(d & 11'h78E), ^(d & 11'h66D), ^(d & 11'h55B)};
        return {d, ^{d, h}, h};
    endfunction
    function automatic logic [10:0] pay(input int i);
        return 11'(i * 157) ^ 11'h2A5;
    endfunction
    function automatic logic [15:0] flip(input int i, input int dbl);
        return (i == dbl) ? 16'h0204 : (i == 0) ? 16'h8000 : (i == 5) ? 16'h0010 :
            (i == 120) ? 16'h0001 : (i == 127) ? 16'h0020 : 16'h0000;
    endfunction
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task results;
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task boot(input logic [7:0] l, input int dbl);
        int n;
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        lat <= l;
        for (int i = 0; i < 128; i++) mdl.mem[i] = enc(pay(i)) ^ flip(i, dbl);
        mdl.wr_cnt = 0;
        repeat (3) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        for (n = 0; n < 5000 && ready_o !== 1'b1; n++) @(negedge core_clk_i);
        if (n == 5000) begin
            bad_count++;
            results();
        end
    endtask
    task check(input int dbl);
        for (int i = 0; i < 8; i++) cmp(cfg_word_o[i], enc(pay(i)));
        for (int i = 0; i < 128; i++) cmp(mdl.mem[i], enc(pay(i)) ^ (i == dbl ? 16'h0204 : 16'h0000));
        cmp({15'h0000, fatal}, {15'h0000, dbl >= 0});
        cmp({12'h000, status_o}, {14'h0000, dbl >= 0, 1'b0});
        cmp(16'(mdl.wr_cnt), 16'h0004);
        cmp({9'h000, state_o}, {9'h000, ewsc_pkg::EWSC_RUN});
        cmp({15'h0000, check_done_o}, 16'h0001);
        @(posedge core_clk_i);
        rd_addr_i <= 7'h78;
        repeat (2) @(negedge core_clk_i);
        cmp({5'h00, rd_payload_o}, {5'h00, pay(120)});
    endtask
    task scen_fix_prompt;
        boot(8'h00, -1);
        check(-1);
    endtask
    task scen_double_slow;
        boot(8'h03, 64);
        check(64);
    endtask
    initial begin
        scen_fix_prompt();
        scen_double_slow();
        results();
    end
endmodule
